// file: bench/tb_top.sv
// testbench: trigger read-out in all packing modes; host-paced and timed read-out in X/Y with prefix only
// assumes: engine model answers starts; host reads exact sample lengths, except four two-byte reads abandoned for a status read
`timescale 1ns/1ps
module tb_top;
  logic        clk_sys, resetn, reg_rd, reg_wr, packing_select, status_prefix_enable;
  logic        acquire_trigger, touch_valid, measure_start, measure_done;
  logic        interrupt_status_clear, data_ready;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, interrupt_status_register, sample_interval, b;
  logic [1:0]  acquisition_policy;
  logic [3:0]  z_divider;
  logic [11:0] x_value, y_value;
  logic [15:0] pressure;
  logic [39:0] cap;
  int          n_fail, checked;
  touch_sample_buffer_port DUT (.clk_sys, .resetn, .reg_rd, .reg_wr, .reg_addr, .reg_wdata,
    .reg_rdata, .packing_select, .status_prefix_enable, .acquisition_policy, .acquire_trigger,
    .z_divider, .interrupt_status_register, .interrupt_status_clear, .touch_valid,
    .measure_start, .measure_done, .x_value, .y_value, .pressure, .sample_interval,
    .data_ready);
  touch_engine_model u_eng (.clk_sys, .resetn, .measure_start, .measure_done, .x_value,
    .y_value, .pressure);
  // clock and the last sample set the engine handed over
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (measure_done) cap <= {x_value, y_value, pressure};
  function automatic logic [7:0] exp_byte(input int i);
    logic [11:0] x, y;
    logic [15:0] z;
    {x, y, z} = cap;
    z = z >> z_divider;
    case (i - (status_prefix_enable ? 1 : 0))
      -1: return 8'h02;
      0: return x[11:4];
      1: return {x[3:0], y[11:8]};
      2: return y[7:0];
      default: return z[7:0];
    endcase
  endfunction : exp_byte
  function automatic int set_len();
    return (packing_select ? 3 : 4) + (status_prefix_enable ? 1 : 0);
  endfunction : set_len
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // every access is a closed transaction before the next one starts
  task automatic rd(input logic [7:0] a);
    @(negedge clk_sys);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    b = reg_rdata;
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask : wr
  task automatic trig;
    @(negedge clk_sys);
    acquire_trigger = 1'b1;
    @(negedge clk_sys);
    acquire_trigger = 1'b0;
  endtask : trig
  task automatic wait_set;
    int k;
    for (k = 0; k < 300 && measure_done !== 1'b1; k++) @(negedge clk_sys);
    for (k = 0; k < 4 && data_ready !== 1'b1; k++) @(negedge clk_sys);
    chk("data_ready", 8'h01, {7'h0, data_ready});
  endtask : wait_set
  task automatic rd_set(input int n);
    for (int i = 0; i < n; i++)
    begin
      rd(touch_pkg::ADDR_DATA_PORT);
      chk("data byte", exp_byte(i), b);
      if (i == 0 && status_prefix_enable)
        chk("isr clear", 8'h01, {7'h0, interrupt_status_clear});
    end
  endtask : rd_set
  task automatic wrap_up;
    if (n_fail == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  // watchdog sized well above the one-millisecond timed run
  initial
  begin
    #1500000;
    n_fail++;
    wrap_up();
  end
  initial
  begin
    int k;
    {reg_rd, reg_wr, acquire_trigger, touch_valid, packing_select} = '0;
    {status_prefix_enable, acquisition_policy, z_divider, reg_addr, reg_wdata} = '0;
    resetn = 1'b0;
    void'($urandom(32'h4DF471B9));
    interrupt_status_register = 8'($urandom);
    repeat (12) @(posedge clk_sys);
    @(negedge clk_sys) resetn = 1'b1;
    chk("rdata reset", 8'hB0, reg_rdata);
    chk("interval reset", 8'h0A, sample_interval);
    b = 8'($urandom);
    wr(touch_pkg::ADDR_SAMPLE_INTERVAL, b);
    rd(touch_pkg::ADDR_SAMPLE_INTERVAL);
    chk("interval rw", reg_wdata, b);
    acquisition_policy = 2'h1;
    touch_valid = 1'b1;
    for (int m = 0; m < 8; m++)
    begin
      {packing_select, status_prefix_enable} = m[1:0];
      z_divider = 4'($urandom);
      trig();
      wait_set();
      if (m[2])
      begin
        rd_set(2);
        rd(touch_pkg::ADDR_INT_STATUS);
        chk("isr read", interrupt_status_register, b);
        trig();
        wait_set();
      end
      rd_set(set_len());
      chk("drained", 8'h00, {7'h0, data_ready});
    end
    acquisition_policy = 2'h2;
    for (int m = 0; m < 2; m++)
    begin
      wait_set();
      rd_set(set_len());
    end
    touch_valid = 1'b0;
    acquisition_policy = 2'h0;
    wr(touch_pkg::ADDR_SAMPLE_INTERVAL, 8'h00);
    touch_valid = 1'b1;
    for (k = 0; k < 60000 && measure_start !== 1'b1; k++) @(negedge clk_sys);
    chk("interval 1ms", 8'h01, {7'h0, (k > 49990 && k < 50010)});
    wait_set();
    rd_set(set_len());
    wrap_up();
  end
endmodule : tb_top

// file: bench/touch_engine_model.sv
// model: conversion engine answering each start with one done pulse
// assumes: starts come one at a time; data valid only with done
`timescale 1ns/1ps
module touch_engine_model #(parameter int DELAY = 20)
(
  input  wire logic   clk_sys,
  input  wire logic   resetn,
  input  wire logic   measure_start,
  output logic        measure_done,
  output logic [11:0] x_value,
  output logic [11:0] y_value,
  output logic [15:0] pressure
);
  int cnt;
  // data toggles outside done so a late capture cannot match by luck
  always @(posedge clk_sys or negedge resetn)
    if (!resetn)
    begin
      cnt <= 0;
      measure_done <= 1'b0;
      {x_value, y_value, pressure} <= '0;
    end
    else
    begin
      cnt <= measure_start ? DELAY : (cnt != 0 ? cnt - 1 : 0);
      measure_done <= (cnt == 1);
      if (cnt == 1)
        {x_value, y_value, pressure} <= 40'({$urandom, $urandom});
      else
        {x_value, y_value, pressure} <= ~{x_value, y_value, pressure};
    end
endmodule : touch_engine_model

// file: bench/touch_sample_buffer_port_asserts.sv
// checker: port-level timing of the touch sample buffer port
// assumes: bound to the design top; one clock domain
`timescale 1ns/1ps
module touch_sample_buffer_port_asserts
(
  input wire logic       clk_sys,
  input wire logic       resetn,
  input wire logic       reg_rd,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] interrupt_status_register,
  input wire logic       interrupt_status_clear,
  input wire logic       touch_valid,
  input wire logic       measure_start,
  input wire logic       measure_done,
  input wire logic [7:0] sample_interval,
  input wire logic       data_ready
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // each output is tied to the request or event that caused it
  a_start_one_cycle: assert property (measure_start |=> !measure_start)
    else $error("start pulse too long");
  a_start_touched: assert property (measure_start |-> $past(touch_valid))
    else $error("start without touch");
  a_interval_write: assert property (reg_wr && reg_addr == touch_pkg::ADDR_SAMPLE_INTERVAL
    |=> sample_interval == $past(reg_wdata))
    else $error("interval not written");
  a_interval_hold: assert property (!reg_wr |=> $stable(sample_interval))
    else $error("interval changed");
  a_isr_read_clear: assert property (reg_rd && reg_addr == touch_pkg::ADDR_INT_STATUS
    |=> interrupt_status_clear && reg_rdata == $past(interrupt_status_register))
    else $error("status read wrong");
  a_clear_cause: assert property (interrupt_status_clear |-> $past(reg_rd))
    else $error("clear without read");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
  a_ready_cause: assert property ($rose(data_ready) |-> $past(measure_done))
    else $error("ready without sample");
endmodule : touch_sample_buffer_port_asserts

bind touch_sample_buffer_port touch_sample_buffer_port_asserts u_chk (.clk_sys, .resetn,
  .reg_rd, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .interrupt_status_register,
  .interrupt_status_clear, .touch_valid, .measure_start, .measure_done, .sample_interval,
  .data_ready);

// file: core/touch_interval_timer.sv
// file: interval timer producing one start pulse per (interval+1) ms
// assumes: clk_sys at the package rate; interval may change at any time
`timescale 1ns/1ps
module touch_interval_timer
(
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  input  wire logic       run,
  input  wire logic [7:0] interval,
  output logic            expire
);
  typedef struct packed
  {
    logic [9:0] pre;
    logic [9:0] us;
    logic [7:0] ms;
    logic       exp;
  } tmr_type;

  tmr_type s_q;
  tmr_type s_d;

  // prescale to a 1 us tick, count 1000 ticks a ms, interval+1 ms a period
  always_comb
  begin
    s_d     = s_q;
    s_d.exp = 1'b0;
    if (!run)
    begin
      s_d.pre = '0;
      s_d.us  = '0;
      s_d.ms  = '0;
    end
    else if (s_q.pre == touch_pkg::TICK_LAST)
    begin
      s_d.pre = '0;
      if (s_q.us == touch_pkg::US_LAST)
      begin
        s_d.us = '0;
        if (s_q.ms >= interval)
        begin
          s_d.ms  = '0;
          s_d.exp = 1'b1;
        end
        else
          s_d.ms = s_q.ms + 8'h01;
      end
      else
        s_d.us = s_q.us + 10'h001;
    end
    else
      s_d.pre = s_q.pre + 10'h001;
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign expire = s_q.exp;
endmodule : touch_interval_timer

// file: core/touch_pkg.sv
// package: constants for the touch sample buffer and read-out port
// assumes: a 50 MHz system clock and a byte-wide register port
package touch_pkg;
  localparam int unsigned CLK_HZ              = 50000000;
  localparam int unsigned TICK_NS             = 1000;           // 1 us interval tick
  localparam int unsigned TICK_CYCLES         = (TICK_NS * (CLK_HZ / 1000000)) / 1000;
  localparam int unsigned US_PER_MS           = 1000;
  localparam logic [9:0]  TICK_LAST           = 10'(TICK_CYCLES - 1);
  localparam logic [9:0]  US_LAST             = 10'(US_PER_MS - 1);

  localparam logic [7:0]  ADDR_DATA_PORT      = 8'h42;
  localparam logic [7:0]  ADDR_SAMPLE_INTERVAL = 8'h43;
  localparam logic [7:0]  ADDR_INT_STATUS     = 8'h0B;
  localparam logic [7:0]  INTERVAL_RESET      = 8'h0A;
  localparam logic [7:0]  DATA_PORT_RESET     = 8'hB0;

  localparam int unsigned VALID_BIT           = 1;
  localparam logic [2:0]  LEN_XYZ             = 3'h4;
  localparam logic [2:0]  LEN_XY              = 3'h3;

  localparam logic [1:0]  POLICY_TIMED        = 2'h0;
  localparam logic [1:0]  POLICY_TRIGGER      = 2'h1;
  localparam logic [1:0]  POLICY_HOST_PACED   = 2'h2;
endpackage : touch_pkg

// file: core/touch_sample_buffer_port.sv
// file: touch sample timing, packing and single-entry read-out buffer
// assumes: conversion engine outside answers each start with one done pulse;
// the host port gives one-cycle read and write strobes with a byte address
//
// What this block does
// - interval is register value plus one milliseconds
// - start one measurement cycle per interval while touched
// - pack X high, X low/Y high, Y low, Z
// - status prefix byte leads sample when enabled
// - status bit1 is data valid, cleared on read
// - reading status byte clears interrupt status
// - acquire trigger resets read pointer when it starts a trigger-mode measurement
// - host-paced mode: completion overwrites, resets pointer
// - timed mode samples even when buffer unread
// - unread buffer is replaced by new sample
// - new sample dropped while read in progress, except in host-paced mode
// - other address access ends partial read
// - interrupt status read clears set bits
// - Z is pressure shifted by divider, low byte
`timescale 1ns/1ps
module touch_sample_buffer_port
(
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // host register port
  input  wire logic        reg_rd,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic [7:0]       reg_rdata,
  // configuration held in neighbouring registers
  input  wire logic        packing_select,
  input  wire logic        status_prefix_enable,
  input  wire logic [1:0]  acquisition_policy,
  input  wire logic        acquire_trigger,
  input  wire logic [3:0]  z_divider,
  input  wire logic [7:0]  interrupt_status_register,
  output logic             interrupt_status_clear,
  // touch detection and conversion engine
  input  wire logic        touch_valid,
  output logic             measure_start,
  input  wire logic        measure_done,
  input  wire logic [11:0] x_value,
  input  wire logic [11:0] y_value,
  input  wire logic [15:0] pressure,
  output logic [7:0]       sample_interval,
  output logic             data_ready
);
  typedef struct packed
  {
    logic [7:0]  interval;
    logic [7:0]  b0;
    logic [7:0]  b1;
    logic [7:0]  b2;
    logic [7:0]  b3;
    logic        valid;
    logic        busy;
    logic        reading;
    logic [2:0]  ptr;
    logic [7:0]  rdata;
    logic        start;
    logic        isr_clr;
  } state_type;

  state_type s_q;
  state_type s_d;

  logic       expire;
  logic       timed_run;
  logic [2:0] len;
  logic [2:0] cidx;
  logic [7:0] coord;
  logic [7:0] z_byte;
  logic [7:0] pick;
  logic       at_status;
  logic       data_rd;

  touch_interval_timer u_timer
  (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .run      (timed_run),
    .interval (s_q.interval),
    .expire   (expire)
  );

  // the timer only runs in timed mode while a touch persists
  assign timed_run = touch_valid && (acquisition_policy == touch_pkg::POLICY_TIMED);

  // pressure reduced by the divider; only the low byte is kept
  assign z_byte = 8'(pressure >> z_divider);

  // packed length with optional status prefix
  always_comb
  begin
    len = packing_select ? touch_pkg::LEN_XY : touch_pkg::LEN_XYZ;
    if (status_prefix_enable)
      len = len + 3'h1;
  end

  // byte selection: pointer 0 is the status byte when prefixed
  assign at_status = status_prefix_enable && (s_q.ptr == 3'h0);
  assign cidx      = status_prefix_enable ? s_q.ptr - 3'h1 : s_q.ptr;
  always_comb
  begin
    case (cidx)
      3'h0:    coord = s_q.b0;
      3'h1:    coord = s_q.b1;
      3'h2:    coord = s_q.b2;
      3'h3:    coord = s_q.b3;
      default: coord = 8'h00;
    endcase
    pick = coord;
    if (at_status)
    begin
      pick = 8'h00;  // reserved bits read as zero
      pick[touch_pkg::VALID_BIT] = s_q.valid;
    end
  end

  assign data_rd = reg_rd && (reg_addr == touch_pkg::ADDR_DATA_PORT);

  // one process owns all buffer, pointer and handshake state
  always_comb
  begin
    s_d         = s_q;
    s_d.start   = 1'b0;
    s_d.isr_clr = 1'b0;

    if (reg_wr && reg_addr == touch_pkg::ADDR_SAMPLE_INTERVAL)
      s_d.interval = reg_wdata;

    // start a measurement: timer in timed mode, trigger, or host-paced refill
    case (acquisition_policy)
      touch_pkg::POLICY_TIMED:
        if (expire && !s_q.busy)
          s_d.start = 1'b1;
      touch_pkg::POLICY_TRIGGER:
        if (acquire_trigger && touch_valid && !s_q.busy)
        begin
          s_d.start   = 1'b1;
          s_d.ptr     = 3'h0;
          s_d.reading = 1'b0;
        end
      touch_pkg::POLICY_HOST_PACED:
        if (touch_valid && !s_q.busy && !s_q.valid && !s_q.reading)
          s_d.start = 1'b1;  // refill only once valid is clear and no read is under way
      default: ;
    endcase
    if (s_d.start)
      s_d.busy = 1'b1;

    // host access to the data port walks the packed sample
    if (data_rd)
    begin
      s_d.rdata = pick;
      if (at_status)
      begin
        s_d.isr_clr = 1'b1;
        s_d.valid   = 1'b0;
      end
      if (s_q.ptr + 3'h1 >= len)
      begin
        s_d.ptr     = 3'h0;
        s_d.reading = 1'b0;
        s_d.valid   = 1'b0;
      end
      else
      begin
        s_d.ptr     = s_q.ptr + 3'h1;
        s_d.reading = 1'b1;
      end
    end
    else if (reg_rd)
    begin
      // a partial read abandoned for another address ends the read but leaves valid as it is
      s_d.ptr     = 3'h0;
      s_d.reading = 1'b0;
      if (reg_addr == touch_pkg::ADDR_SAMPLE_INTERVAL)
        s_d.rdata = s_q.interval;
      else
        s_d.rdata = 8'h00;
      if (reg_addr == touch_pkg::ADDR_INT_STATUS)
      begin
        s_d.rdata   = interrupt_status_register;
        s_d.isr_clr = 1'b1;
      end
    end
    else if (reg_wr && reg_addr != touch_pkg::ADDR_DATA_PORT && s_q.reading)
    begin
      s_d.ptr     = 3'h0;
      s_d.reading = 1'b0;
    end

    // a finished sample lands unless a read is under way; host-paced mode ends the read first
    if (measure_done)
    begin
      s_d.busy = 1'b0;
      if (acquisition_policy == touch_pkg::POLICY_HOST_PACED)
      begin
        s_d.ptr     = 3'h0;
        s_d.reading = 1'b0;
      end
      if (!s_d.reading)
      begin
        s_d.b0    = x_value[11:4];
        s_d.b1    = {x_value[3:0], y_value[11:8]};
        s_d.b2    = y_value[7:0];
        s_d.b3    = z_byte;
        s_d.valid = 1'b1;  // set wins over a same-cycle read clear
        s_d.ptr   = 3'h0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      s_q          <= '0;
      s_q.interval <= touch_pkg::INTERVAL_RESET;
      s_q.rdata    <= touch_pkg::DATA_PORT_RESET;
    end
    else
      s_q <= s_d;
  end

  // outputs all come from state; the host interval choice is its own concern
  assign reg_rdata              = s_q.rdata;
  assign measure_start          = s_q.start;
  assign interrupt_status_clear = s_q.isr_clr;
  assign sample_interval        = s_q.interval;
  assign data_ready             = s_q.valid;
endmodule : touch_sample_buffer_port
